/* File: shared/smpcmp_pkg.sv */
// constants and carriers for the comparator digital control block
// assumes a 250 MHz system clock standing in for the instruction clock
package smpcmp_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned GLITCH_TIME_PS  = 66000;
  localparam int unsigned GLITCH_CYCLES   = (GLITCH_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FILT_CNT_W      = 5;

  localparam logic [3:0] ADDR_CONTROL     = 4'h0;
  localparam logic [3:0] ADDR_DAC         = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'hC;

  localparam int unsigned BIT_ENABLE      = 15;
  localparam int unsigned BIT_STOP_IDLE   = 13;
  localparam int unsigned BIT_INSEL_HI    = 7;
  localparam int unsigned BIT_INSEL_LO    = 6;
  localparam int unsigned BIT_EXTERNAL_REFERENCE_SELECT      = 5;
  localparam int unsigned BIT_STATUS      = 3;
  localparam int unsigned BIT_POLARITY    = 1;
  localparam int unsigned BIT_RANGE       = 0;
  localparam int unsigned DAC_W           = 10;

  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [DAC_W-1:0] DAC_RESET  = 10'h000;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_RESET = 5'h00;

  typedef struct packed {
    logic       enable;
    logic       stop_in_idle;
    logic [1:0] input_select;
    logic       external_reference_select;
    logic       output_polarity;
    logic       range_high;
  } smpcmp_ctrl_s;

  typedef struct packed {
    logic             dac_enable;
    logic [DAC_W-1:0] dac_reference_value;
    logic             external_reference_select;
    logic             range_high;
    logic             comparator_enable;
    logic [1:0]       input_select;
    logic [3:0]       pad_digital_input_disable;
  } smpcmp_analog_s;
endpackage

/* File: src/smpcmp_ctrl.sv */
// comparator digital control: registers, glitch filter, event pulse, irq
// assumes the raw comparator output is asynchronous; sleep and idle flags are synchronous levels
`timescale 1ns/10ps
// What this block does
// - filter out comparator transients shorter than FILT_CYCLES system clock cycles (17 by default)
// - in sleep or idle, bypass filter, send comparator asynchronously to the wake request
// - asynchronous path wakes processor from sleep or idle on threshold crossing
// - any stop-in-idle bit set disables all comparators during idle
// - one-cycle event pulse drives adc trigger and interrupt request
// - enable clear holds dac and comparator off; set enables module
// - input select codes 00..11 pick input pins a, b, c, d
// - range bit set gives high dac range, clear the internal low range
// - polarity bit set inverts comparator output, clear passes it
// - comparator negative input is the dac, positive the selected pin
// - one event drives adc trigger and pwm in the same cycle, interrupt one cycle later
// - enabled module disables digital input buffer of the selected pad
// - dac driven from the ten-bit dac value register
module smpcmp_ctrl #(
  parameter int unsigned FILT_CYCLES = smpcmp_pkg::GLITCH_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic [3:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic [15:0]                   reg_rdata,
  input  wire logic                     comparator_raw,
  input  wire logic                     sys_sleep,
  input  wire logic                     sys_idle,
  input  wire logic                     other_stop_in_idle,
  output logic                          stop_in_idle_out,
  output smpcmp_pkg::smpcmp_analog_s    analog,
  output logic                          event_pulse,
  output logic                          adc_trigger,
  output logic                          pwm_event,
  output logic                          wake_request,
  output logic                          irq
);
  typedef struct packed {
    logic [1:0]                              rst_sync;
    logic [1:0]                              cmp_sync;
    smpcmp_pkg::smpcmp_ctrl_s                ctrl;
    logic [smpcmp_pkg::DAC_W-1:0]            dac;
    logic [smpcmp_pkg::FILT_CNT_W-1:0]       filt_cnt;
    logic                                    filtered;
    logic                                    filtered_prev;
    logic                                    event_pulse;
    logic                                    pwm_event;
    logic                                    wake;
    logic [1:0]                              irq_status;
    logic [1:0]                              irq_mask;
    logic                                    irq;
    logic [15:0]                             rdata;
    smpcmp_pkg::smpcmp_analog_s              analog;
    logic                                    sidl_out;
  } smpcmp_state_s;

  smpcmp_state_s st_q;
  smpcmp_state_s st_d;
  logic          rst_n_int;
  logic          low_power;
  logic          active;
  logic          cmp_level;
  logic          async_level;

  assign rst_n_int = st_q.rst_sync[1];
  assign low_power = sys_sleep | sys_idle;

  // combinational path for wake while clocks stop
  assign async_level = comparator_raw ^ st_q.ctrl.output_polarity;

  always_comb
  begin
    st_d          = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.cmp_sync = {st_q.cmp_sync[0], comparator_raw};

    // module off when disabled or group stop in idle
    active = st_q.ctrl.enable & ~(sys_idle & (st_q.ctrl.stop_in_idle | other_stop_in_idle));
    cmp_level = active & (st_q.cmp_sync[1] ^ st_q.ctrl.output_polarity);

    // glitch filter: level must hold FILT_CYCLES before it is accepted
    if (cmp_level == st_q.filtered)
    begin
      st_d.filt_cnt = smpcmp_pkg::FILT_CNT_RESET;
    end
    else if (st_q.filt_cnt >= smpcmp_pkg::FILT_CNT_W'(FILT_CYCLES - 1))
    begin
      st_d.filtered = cmp_level;
      st_d.filt_cnt = smpcmp_pkg::FILT_CNT_RESET;
    end
    else
    begin
      st_d.filt_cnt = st_q.filt_cnt + 1'b1;
    end
    if (low_power)
    begin
      st_d.filtered = cmp_level;
      st_d.filt_cnt = smpcmp_pkg::FILT_CNT_RESET;
    end

    st_d.filtered_prev = st_q.filtered;
    st_d.event_pulse   = st_q.filtered & ~st_q.filtered_prev;
    st_d.pwm_event     = st_q.filtered;
    st_d.wake          = low_power & active & (st_q.cmp_sync[1] ^ st_q.ctrl.output_polarity);

    // status bit 0: comparator event, bit 1: wake event; read clears, set wins
    st_d.rdata = 16'h0000;
    if (reg_read)
    begin
      case (reg_addr)
        smpcmp_pkg::ADDR_CONTROL:
        begin
          st_d.rdata[smpcmp_pkg::BIT_ENABLE]    = st_q.ctrl.enable;
          st_d.rdata[smpcmp_pkg::BIT_STOP_IDLE] = st_q.ctrl.stop_in_idle;
          st_d.rdata[smpcmp_pkg::BIT_INSEL_HI:smpcmp_pkg::BIT_INSEL_LO] = st_q.ctrl.input_select;
          st_d.rdata[smpcmp_pkg::BIT_EXTERNAL_REFERENCE_SELECT]    = st_q.ctrl.external_reference_select;
          st_d.rdata[smpcmp_pkg::BIT_STATUS]    = st_q.filtered;
          st_d.rdata[smpcmp_pkg::BIT_POLARITY]  = st_q.ctrl.output_polarity;
          st_d.rdata[smpcmp_pkg::BIT_RANGE]     = st_q.ctrl.range_high;
        end
        smpcmp_pkg::ADDR_DAC:        st_d.rdata[smpcmp_pkg::DAC_W-1:0] = st_q.dac;
        smpcmp_pkg::ADDR_IRQ_STATUS:
        begin
          st_d.rdata[1:0] = st_q.irq_status;
          st_d.irq_status = 2'h0;
        end
        smpcmp_pkg::ADDR_IRQ_MASK:   st_d.rdata[1:0] = st_q.irq_mask;
        default:                     st_d.rdata = 16'h0000;
      endcase
    end
    if (reg_write)
    begin
      case (reg_addr)
        smpcmp_pkg::ADDR_CONTROL:
        begin
          st_d.ctrl.enable       = reg_wdata[smpcmp_pkg::BIT_ENABLE];
          st_d.ctrl.stop_in_idle = reg_wdata[smpcmp_pkg::BIT_STOP_IDLE];
          st_d.ctrl.input_select = reg_wdata[smpcmp_pkg::BIT_INSEL_HI:smpcmp_pkg::BIT_INSEL_LO];
          st_d.ctrl.external_reference_select = reg_wdata[smpcmp_pkg::BIT_EXTERNAL_REFERENCE_SELECT];
          st_d.ctrl.output_polarity = reg_wdata[smpcmp_pkg::BIT_POLARITY];
          st_d.ctrl.range_high   = reg_wdata[smpcmp_pkg::BIT_RANGE];
        end
        smpcmp_pkg::ADDR_DAC:      st_d.dac = reg_wdata[smpcmp_pkg::DAC_W-1:0];
        smpcmp_pkg::ADDR_IRQ_MASK: st_d.irq_mask = reg_wdata[1:0];
        default:                   st_d.dac = st_q.dac;
      endcase
    end
    if (st_q.event_pulse)
    begin
      st_d.irq_status[0] = 1'b1;
    end
    if (st_q.wake)
    begin
      st_d.irq_status[1] = 1'b1;
    end
    st_d.irq = |(st_d.irq_status & st_q.irq_mask);

    // analog side controls
    st_d.analog.dac_enable                = active;
    st_d.analog.comparator_enable         = active;
    st_d.analog.dac_reference_value       = st_q.dac;
    st_d.analog.external_reference_select = st_q.ctrl.external_reference_select;
    st_d.analog.range_high                = st_q.ctrl.range_high;
    st_d.analog.input_select              = st_q.ctrl.input_select;
    st_d.analog.pad_digital_input_disable = 4'h0;
    if (st_q.ctrl.enable)
    begin
      st_d.analog.pad_digital_input_disable[st_q.ctrl.input_select] = 1'b1;
    end
    st_d.sidl_out = st_q.ctrl.stop_in_idle;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else if (!rst_n_int)
    begin
      st_q          <= '0;
      st_q.rst_sync <= st_d.rst_sync;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata        = st_q.rdata;
  assign analog           = st_q.analog;
  assign event_pulse      = st_q.event_pulse;
  assign adc_trigger      = st_q.event_pulse;
  assign pwm_event        = st_q.pwm_event;
  assign irq              = st_q.irq;
  assign stop_in_idle_out = st_q.sidl_out;
  // wake leaves combinationally from the pin so it works with clocks stopped
  assign wake_request     = st_q.wake | (low_power & st_q.analog.comparator_enable & async_level);
endmodule // smpcmp_ctrl

/* File: tb/smpcmp_far_end.sv */
// far-end model: converter start input counting triggers
// samples the trigger on the system clock as the converter would
`timescale 1ns/10ps
module smpcmp_far_end (
  input wire logic clk_sys,
  input wire logic adc_trigger,
  output int       n_adc
);
  initial n_adc = 0;
  always @(posedge clk_sys)
    if (adc_trigger === 1'b1) n_adc <= n_adc + 1;
endmodule // smpcmp_far_end

/* File: tb/smpcmp_ctrl_assertions.sv */
// port checker for the comparator control block
// bound into smpcmp_ctrl; sees only its ports
`timescale 1ns/10ps
module smpcmp_ctrl_chk (
  input wire logic                       clk_sys,
  input wire logic                       rstn,
  input wire logic                       reg_read,
  input wire logic [3:0]                 reg_addr,
  input wire logic [15:0]                reg_rdata,
  input wire logic                       sys_idle,
  input wire logic                       other_stop_in_idle,
  input wire logic                       stop_in_idle_out,
  input wire smpcmp_pkg::smpcmp_analog_s analog,
  input wire logic                       event_pulse,
  input wire logic                       adc_trigger,
  input wire logic                       pwm_event
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  pulse_one_a: assert property (event_pulse |=> !event_pulse)
    else $error("event pulse too long");
  adc_pair_a: assert property (adc_trigger == event_pulse)
    else $error("adc trigger apart from event");
  pwm_rise_a: assert property ($rose(pwm_event) |-> event_pulse)
    else $error("level rise without event");
  off_pair_a: assert property (analog.comparator_enable |-> analog.dac_enable)
    else $error("comparator on with dac off");
  pad_sel_a: assert property (analog.pad_digital_input_disable != 4'h0 |->
    analog.pad_digital_input_disable == 4'h1 << analog.input_select) else $error("wrong pad disabled");
  idle_stop_a: assert property (sys_idle && (stop_in_idle_out || other_stop_in_idle) |->
    ##[1:2] !analog.comparator_enable) else $error("comparator on in idle");
  off_quiet_a: assert property (!analog.dac_enable && !$past(analog.dac_enable) &&
    !$past(analog.dac_enable, 2) |-> !event_pulse) else $error("event while disabled");
  rsvd_zero_a: assert property ($past(reg_read) && $past(reg_addr) == smpcmp_pkg::ADDR_CONTROL |->
    (reg_rdata & 16'h5F14) == 16'h0000) else $error("reserved control bits set");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
endmodule // smpcmp_ctrl_chk
bind smpcmp_ctrl smpcmp_ctrl_chk u_chk (.clk_sys, .rstn, .reg_read, .reg_addr, .reg_rdata, .sys_idle,
  .other_stop_in_idle, .stop_in_idle_out, .analog, .event_pulse, .adc_trigger, .pwm_event);

/* File: tb/smpcmp_ctrl_tb.sv */
// bench: control settings table, then filter, events, irq and power modes
// short filter count; far-end model counts converter triggers
`timescale 1ns/10ps
module smpcmp_ctrl_tb;
  typedef struct packed {logic [15:0] ctrl; logic [15:0] rb; logic [3:0] pad;} smpcmp_row_s;
  logic        clk_sys = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, comparator_raw = 1'b0;
  logic        sys_sleep = 1'b0, sys_idle = 1'b0, other_stop_in_idle = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, q, c;
  logic        stop_in_idle_out, event_pulse, adc_trigger, pwm_event, wake_request, irq;
  int          n_errors = 0, comparisons = 0, n_adc, a0, hits;
  smpcmp_pkg::smpcmp_analog_s analog;
  smpcmp_row_s rows [5] = '{'{16'h8000, 16'h8000, 4'h1}, '{16'h8041, 16'h8041, 4'h2},
    '{16'h80A2, 16'h80AA, 4'h4}, '{16'h80E0, 16'h80E0, 4'h8}, '{16'h0040, 16'h0040, 4'h0}};
  always #2 clk_sys = ~clk_sys;
  smpcmp_ctrl #(.FILT_CYCLES(2)) dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .comparator_raw, .sys_sleep, .sys_idle, .other_stop_in_idle, .stop_in_idle_out, .analog, .event_pulse,
    .adc_trigger, .pwm_event, .wake_request, .irq);
  smpcmp_far_end far (.clk_sys, .adc_trigger, .n_adc);
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    comparisons++;
    if (s !== e)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      n_errors++;
    end
  endtask
  // one write or read cycle; read data land in q
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_write <= w;
    reg_read  <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // n cycles, counting event pulse cycles
  task automatic run(input int n);
    hits = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      #1 hits += int'(event_pulse === 1'b1);
    end
  endtask
  task conclude;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, smpcmp_pkg::ADDR_CONTROL, 16'h0000);
    chk(q, smpcmp_pkg::CONTROL_RESET);
    foreach (rows[i])
    begin
      c = rows[i].ctrl;
      bus(1, smpcmp_pkg::ADDR_CONTROL, c);
      run(8);
      chk(analog, {c[15], 10'h000, c[5], c[0], c[15], c[7:6], rows[i].pad});
      bus(0, smpcmp_pkg::ADDR_CONTROL, 16'h0000);
      chk(q, rows[i].rb);
    end
    $display("control table done");
    bus(1, smpcmp_pkg::ADDR_DAC, 16'hFFFF);
    bus(0, smpcmp_pkg::ADDR_DAC, 16'h0000);
    chk(q, 16'h03FF);
    chk(analog.dac_reference_value, 10'h3FF);
    bus(0, 4'h2, 16'h0000);
    chk(q, 16'h0000);
    $display("dac and map done");
    bus(1, smpcmp_pkg::ADDR_CONTROL, 16'h8000);
    bus(1, smpcmp_pkg::ADDR_IRQ_MASK, 16'h0001);
    bus(0, smpcmp_pkg::ADDR_IRQ_STATUS, 16'h0000);
    a0 = n_adc;
    comparator_raw <= 1'b1;
    @(posedge clk_sys);
    comparator_raw <= 1'b0;
    run(12);
    chk(hits, 0);
    comparator_raw <= 1'b1;
    run(12);
    chk(hits, 1);
    chk(n_adc - a0, 1);
    chk(irq, 1'b1);
    chk(pwm_event, 1'b1);
    bus(1, smpcmp_pkg::ADDR_IRQ_MASK, 16'h0000);
    run(1);
    chk(irq, 1'b0);
    bus(1, smpcmp_pkg::ADDR_IRQ_MASK, 16'h0001);
    run(1);
    chk(irq, 1'b1);
    bus(0, smpcmp_pkg::ADDR_IRQ_STATUS, 16'h0000);
    chk(q[0], 1'b1);
    run(1);
    chk(irq, 1'b0);
    $display("event and irq done");
    comparator_raw <= 1'b0;
    sys_sleep <= 1'b1;
    run(8);
    // async path answers before the synchroniser has seen the pin
    comparator_raw <= 1'b1;
    #1 chk(wake_request, 1'b1);
    @(posedge clk_sys);
    comparator_raw <= 1'b0;
    run(6);
    chk(hits, 1);
    comparator_raw <= 1'b1;
    run(4);
    chk(wake_request, 1'b1);
    bus(0, smpcmp_pkg::ADDR_IRQ_STATUS, 16'h0000);
    chk(q[1:0], 2'b11);
    sys_sleep <= 1'b0;
    sys_idle <= 1'b1;
    other_stop_in_idle <= 1'b1;
    run(3);
    chk(analog.comparator_enable, 1'b0);
    other_stop_in_idle <= 1'b0;
    bus(1, smpcmp_pkg::ADDR_CONTROL, 16'hA000);
    run(3);
    chk({stop_in_idle_out, analog.comparator_enable}, 2'b10);
    sys_idle <= 1'b0;
    run(3);
    chk(analog.comparator_enable, 1'b1);
    $display("power modes done");
    // second reset in mid-run
    rstn <= 1'b0;
    run(2);
    chk(analog, 20'h00000);
    chk({irq, pwm_event, stop_in_idle_out, reg_rdata}, 20'h00000);
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, smpcmp_pkg::ADDR_CONTROL, 16'h0000);
    chk(q, smpcmp_pkg::CONTROL_RESET);
    $display("reset done");
    conclude;
  end
endmodule // smpcmp_ctrl_tb
